// >>> rtl/mrx_top.sv
// Purpose: master receiver of a byte-oriented two-wire serial interface
// Assumes: classic wishbone slave, open-drain lines with external pull-ups
// Notes:   master transmitter data path is kept minimal; no slave modes
//
// Behaviour
// RULE1: master only after START; read bit picks receiver
// RULE2: status codes read with prescaler bits zero
// RULE3: host requests START with flag, start, enable
// RULE4: writing one clears flag; zero leaves it
// RULE5: START waits until bus is free
// RULE6: START sent sets flag, status 0x08
// RULE7: host loads read address, clears flag
// RULE8: after address read, status 0x38/0x40/0x48
// RULE9: host reads byte only while flag set
// RULE10: last wanted byte answered with not-acknowledge
// RULE11: host requests STOP with stop bit
// RULE12: host requests repeated START with start bit
// RULE13: repeated START reports 0x10, keeps bus
// RULE14: from 0x10 write address switches to transmitter
// RULE15: lost arbitration releases bus or restarts
// RULE16: acknowledge enable chooses ACK or NACK next
// RULE17: received byte reports 0x50 or 0x58
// RULE18: 0x48/0x58 clear gives restart, stop, both
// RULE19: stop request clears itself after STOP
// RULE20: data write with flag low sets collision
// RULE21: interrupt while flag and irq enable set
// RULE22: serial clock held low while flag set; code releases it at once on lost arbitration (0x38)
`timescale 1ns/100ps
`include "mrx_params.svh"
module mrx_top #(
	parameter int QUARTER = `MRX_QUARTER_NS / `MRX_CLK_NS
) (
	input  wire logic        I_CLOCK,
	input  wire logic        I_RST_N,
	input  wire logic        I_WB_CYC,
	input  wire logic        I_WB_STB,
	input  wire logic        I_WB_WE,
	input  wire logic [7:0]  I_WB_ADR,
	input  wire logic [3:0]  I_WB_SEL,
	input  wire logic [31:0] I_WB_DAT,
	output logic      [31:0] O_WB_DAT,
	output logic             O_WB_ACK,
	input  wire logic        I_SCL,
	output logic             O_SCL,
	output logic             O_SCL_OE,
	input  wire logic        I_SDA,
	output logic             O_SDA,
	output logic             O_SDA_OE,
	output logic             O_IRQ
);

	mrx_pkg::mrx_state_e state;       // bus engine state
	logic [1:0]  step;                // quarter within the current bit or condition
	logic [3:0]  idx;                 // bit counter, 8 down to 0 (0 = ack)
	logic [7:0]  shreg;               // shift register, out at msb, in at lsb
	logic        rx_mode;             // address carried the read bit
	logic        addr_phase;          // the byte in flight is the address
	logic        ack_bit;             // level to drive on the ack bit when receiving
	logic        got_ack;             // slave acknowledged our byte
	logic        owner;               // this master holds the bus
	logic        busy;                // a transfer is running on the bus
	logic [7:0]  status;              // status code
	logic        flag;                // operation complete flag
	logic        ack_en;              // acknowledge enable
	logic        start_req;           // begin condition request
	logic        stop_req;            // halt condition request
	logic        wcol;                // write collision flag
	logic        enable;              // interface enable
	logic        irq_en;              // interrupt enable
	logic [7:0]  data;                // byte register
	logic        go;                  // flag was just cleared by the host
	logic        flag_set;            // engine finished a step
	logic        rx_load;             // engine received a data byte
	logic        stop_done;           // engine put STOP on the bus
	logic        tick;                // quarter-bit pulse
	logic [1:0]  lines;               // synchronised {scl, sda}
	logic [1:0]  lines_d;             // one cycle older copy for edge finding
	logic        scl_s;
	logic        sda_s;
	logic        tx_now;              // this byte is driven by us
	logic        bit_out;             // level we want on the data line
	logic        own_bit;             // a released one here must read back high
	logic        wb_req;              // valid bus request
	logic        wr_ok;               // write taken this edge
	logic [7:0]  wr_byte;

	assign scl_s   = lines[1];
	assign sda_s   = lines[0];
	assign wb_req  = I_WB_CYC & I_WB_STB;
	assign wr_ok   = wb_req & I_WB_WE & O_WB_ACK & I_WB_SEL[0];
	assign wr_byte = I_WB_DAT[7:0];
	assign tx_now  = addr_phase | ~rx_mode;
	assign bit_out = (idx != `MRX_ACK_BIT) ? (tx_now ? shreg[7] : 1'b1) : (tx_now ? 1'b1 : ack_bit);
	assign own_bit = (idx != `MRX_ACK_BIT) ? tx_now : ~tx_now;

	// pins pass two flip-flops before any logic reads them
	mrx_sync #(
		.WIDTH (2)
	) u_sync (
		.i_clk   (I_CLOCK),
		.i_rst_n (I_RST_N),
		.i_async ({I_SCL, I_SDA}),
		.o_sync  (lines)
	);

	// quarter-bit timing only while a sequence drives the lines
	mrx_tick #(
		.QUARTER (QUARTER)
	) u_tick (
		.i_clk   (I_CLOCK),
		.i_rst_n (I_RST_N),
		.i_run   (state == mrx_pkg::MRX_START || state == mrx_pkg::MRX_BYTE || state == mrx_pkg::MRX_STOP),
		.o_tick  (tick)
	);

	// bus free detection from START and STOP seen on the lines
	always_ff @(posedge I_CLOCK or negedge I_RST_N) begin
		if (!I_RST_N) begin
			lines_d <= 2'h3;
			busy    <= 1'b0;
		end else begin
			lines_d <= lines;
			if (scl_s && lines_d[1] && lines_d[0] && !sda_s) begin
				busy <= 1'b1;    // falling data with clock high
			end else if (scl_s && lines_d[1] && !lines_d[0] && sda_s) begin
				busy <= 1'b0;    // rising data with clock high
			end
		end
	end

	// wishbone: ack one cycle after the request, write commits on the ack edge
	always_ff @(posedge I_CLOCK or negedge I_RST_N) begin
		if (!I_RST_N) begin
			O_WB_ACK <= 1'b0;
			O_WB_DAT <= 32'h00000000;
		end else begin
			O_WB_ACK <= wb_req & ~O_WB_ACK;
			if (wb_req && !O_WB_ACK) begin
				unique case (I_WB_ADR)
					`MRX_ADR_CTRL: O_WB_DAT <= {24'h000000, flag, ack_en, start_req, stop_req, wcol, enable, 1'b0, irq_en};
					`MRX_ADR_STAT: O_WB_DAT <= {24'h000000, status & `MRX_ST_MASK}; // [RULE2]
					`MRX_ADR_DATA: O_WB_DAT <= {24'h000000, data}; // [RULE9]
					default:       O_WB_DAT <= 32'h00000000;        // unmapped reads zero
				endcase
			end
		end
	end

	// control register; hardware set of the flag wins over a host clear
	always_ff @(posedge I_CLOCK or negedge I_RST_N) begin
		if (!I_RST_N) begin
			flag      <= 1'b0;
			ack_en    <= 1'b0;
			start_req <= 1'b0;
			stop_req  <= 1'b0;
			enable    <= 1'b0;
			irq_en    <= 1'b0;
			go        <= 1'b0;
		end else begin
			go <= wr_ok && I_WB_ADR == `MRX_ADR_CTRL && wr_byte[`MRX_B_FLAG] && flag; // [RULE4]
			if (flag_set) begin
				flag <= 1'b1;
			end else if (wr_ok && I_WB_ADR == `MRX_ADR_CTRL && wr_byte[`MRX_B_FLAG]) begin
				flag <= 1'b0;    // a written zero leaves the flag alone [RULE4]
			end
			if (wr_ok && I_WB_ADR == `MRX_ADR_CTRL) begin
				ack_en    <= wr_byte[`MRX_B_ACKEN];
				start_req <= wr_byte[`MRX_B_START];
				enable    <= wr_byte[`MRX_B_EN];
				irq_en    <= wr_byte[`MRX_B_IRQEN];
			end
			if (stop_done) begin
				stop_req <= 1'b0;    // [RULE19]
			end else if (wr_ok && I_WB_ADR == `MRX_ADR_CTRL) begin
				stop_req <= wr_byte[`MRX_B_STOP];
			end
		end
	end

	// byte register and collision flag
	always_ff @(posedge I_CLOCK or negedge I_RST_N) begin
		if (!I_RST_N) begin
			data <= `MRX_RST_DATA;
			wcol <= 1'b0;
		end else if (rx_load) begin
			data <= shreg;    // received byte visible with the flag [RULE17]
		end else if (wr_ok && I_WB_ADR == `MRX_ADR_DATA) begin
			if (flag) begin
				data <= wr_byte;
				wcol <= 1'b0;
			end else begin
				wcol <= 1'b1;    // write discarded [RULE20]
			end
		end
	end

	// interrupt request follows the flag; registered so the pin is a flop
	always_ff @(posedge I_CLOCK or negedge I_RST_N) begin
		if (!I_RST_N) begin
			O_IRQ <= 1'b0;
		end else begin
			O_IRQ <= flag & irq_en;    // [RULE21]
		end
	end

	// open-drain pins only ever pull low
	always_ff @(posedge I_CLOCK or negedge I_RST_N) begin
		if (!I_RST_N) begin
			O_SCL <= 1'b0;
			O_SDA <= 1'b0;
		end else begin
			O_SCL <= 1'b0;
			O_SDA <= 1'b0;
		end
	end

	// bus engine: conditions, bits and the decision on each flag clear
	always_ff @(posedge I_CLOCK or negedge I_RST_N) begin
		if (!I_RST_N) begin
			state      <= mrx_pkg::MRX_IDLE;
			step       <= 2'h0;
			idx        <= 4'h0;
			shreg      <= `MRX_RST_BYTE;
			rx_mode    <= 1'b0;
			addr_phase <= 1'b0;
			ack_bit    <= 1'b1;
			got_ack    <= 1'b0;
			owner      <= 1'b0;
			status     <= `MRX_ST_IDLE;
			O_SCL_OE   <= 1'b0;
			O_SDA_OE   <= 1'b0;
			flag_set   <= 1'b0;
			rx_load    <= 1'b0;
			stop_done  <= 1'b0;
		end else begin
			flag_set  <= 1'b0;
			rx_load   <= 1'b0;
			stop_done <= 1'b0;
			if (!enable) begin
				// disabled: let go of everything at once
				state    <= mrx_pkg::MRX_IDLE;
				owner    <= 1'b0;
				status   <= `MRX_ST_IDLE;
				O_SCL_OE <= 1'b0;
				O_SDA_OE <= 1'b0;
			end else begin
				unique case (state)
					mrx_pkg::MRX_IDLE: begin
						// never master without a START first [RULE1]
						if (start_req && !flag && !busy) begin    // [RULE5]
							state <= mrx_pkg::MRX_START;
							step  <= 2'h0;
						end
					end
					mrx_pkg::MRX_START: if (tick) begin
						unique case (step)
							2'h0: O_SDA_OE <= 1'b0;
							2'h1: O_SCL_OE <= 1'b0;
							2'h2: if (scl_s) O_SDA_OE <= 1'b1;
							2'h3: begin
								O_SCL_OE <= 1'b1;
								status   <= owner ? `MRX_ST_RESTART : `MRX_ST_START; // [RULE6] [RULE13]
								owner    <= 1'b1;
								flag_set <= 1'b1;
								state    <= mrx_pkg::MRX_HOLD;
							end
						endcase
						if (step != 2'h2 || scl_s) step <= step + 2'h1;
					end
					mrx_pkg::MRX_HOLD: if (go) begin
						// clock stays low until the host clears the flag [RULE22]
						if (status == `MRX_ST_START || status == `MRX_ST_RESTART) begin
							shreg      <= data;
							rx_mode    <= data[0];    // read bit: receiver, else transmitter [RULE1] [RULE14]
							addr_phase <= 1'b1;
							idx        <= `MRX_LAST_BIT;
							step       <= 2'h0;
							state      <= mrx_pkg::MRX_BYTE;
						end else if (stop_req) begin
							state <= mrx_pkg::MRX_STOP;    // start also set: START follows from idle [RULE18]
							step  <= 2'h0;
						end else if (start_req) begin
							state <= mrx_pkg::MRX_START;    // repeated START [RULE18]
							step  <= 2'h0;
						end else begin
							shreg   <= data;
							ack_bit <= ~ack_en;    // zero drives ACK, one leaves NACK [RULE16] [RULE10]
							idx     <= `MRX_LAST_BIT;
							step    <= 2'h0;
							state   <= mrx_pkg::MRX_BYTE;
						end
					end
					mrx_pkg::MRX_BYTE: if (tick) begin
						unique case (step)
							2'h0: begin
								O_SDA_OE <= ~bit_out;
								step     <= 2'h1;
							end
							2'h1: begin
								O_SCL_OE <= 1'b0;
								step     <= 2'h2;
							end
							2'h2: if (scl_s) begin
								if (own_bit && bit_out && !sda_s) begin
									// another master pulled low: give up the bus [RULE15]
									O_SCL_OE <= 1'b0;
									O_SDA_OE <= 1'b0;
									owner    <= 1'b0;
									status   <= `MRX_ST_LOST;    // [RULE8]
									flag_set <= 1'b1;
									state    <= mrx_pkg::MRX_LOST;
								end else begin
									if (idx != `MRX_ACK_BIT) shreg <= {shreg[6:0], sda_s};
									else got_ack <= ~sda_s;
									step <= 2'h3;
								end
							end
							2'h3: begin
								O_SCL_OE <= 1'b1;
								step     <= 2'h0;
								if (idx != `MRX_ACK_BIT) begin
									idx <= idx - 4'h1;
								end else begin
									O_SDA_OE   <= 1'b0;
									addr_phase <= 1'b0;
									flag_set   <= 1'b1;
									state      <= mrx_pkg::MRX_HOLD;
									if (addr_phase && rx_mode) begin
										status <= got_ack ? `MRX_ST_AR_ACK : `MRX_ST_AR_NACK; // [RULE8]
									end else if (addr_phase) begin
										status <= got_ack ? `MRX_ST_AW_ACK : `MRX_ST_AW_NACK; // [RULE14]
									end else if (rx_mode) begin
										status  <= ack_bit ? `MRX_ST_DR_NACK : `MRX_ST_DR_ACK; // [RULE17]
										rx_load <= 1'b1;
									end else begin
										status <= got_ack ? `MRX_ST_DW_ACK : `MRX_ST_DW_NACK;
									end
								end
							end
						endcase
					end
					mrx_pkg::MRX_STOP: if (tick) begin
						unique case (step)
							2'h0: O_SDA_OE <= 1'b1;
							2'h1: O_SCL_OE <= 1'b0;
							2'h2: if (scl_s) O_SDA_OE <= 1'b0;
							2'h3: begin
								stop_done <= 1'b1;
								owner     <= 1'b0;
								status    <= `MRX_ST_IDLE;
								state     <= mrx_pkg::MRX_IDLE;
							end
						endcase
						if (step != 2'h2 || scl_s) step <= step + 2'h1;
					end
					mrx_pkg::MRX_LOST: if (go) begin
						// idle retries START once free if start is set [RULE15]
						status <= `MRX_ST_IDLE;
						state  <= mrx_pkg::MRX_IDLE;
					end
					default: state <= mrx_pkg::MRX_IDLE;
				endcase
			end
		end
	end

endmodule

// >>> rtl/mrx_params.svh
// Purpose: named constants of the two-wire master receiver block
// Assumes: included by bare name from every design file that needs it
// Notes:   register byte addresses, control bit positions, status codes, timing
`ifndef MRX_PARAMS_SVH
`define MRX_PARAMS_SVH

// register byte addresses on the wishbone bus
`define MRX_ADR_CTRL    8'h00
`define MRX_ADR_STAT    8'h04
`define MRX_ADR_DATA    8'h08

// bit positions inside the control register
`define MRX_B_FLAG      7
`define MRX_B_ACKEN     6
`define MRX_B_START     5
`define MRX_B_STOP      4
`define MRX_B_WCOL      3
`define MRX_B_EN        2
`define MRX_B_IRQEN     0

// status codes, prescaler field always reads as zero
`define MRX_ST_START    8'h08
`define MRX_ST_RESTART  8'h10
`define MRX_ST_AW_ACK   8'h18
`define MRX_ST_AW_NACK  8'h20
`define MRX_ST_DW_ACK   8'h28
`define MRX_ST_DW_NACK  8'h30
`define MRX_ST_LOST     8'h38
`define MRX_ST_AR_ACK   8'h40
`define MRX_ST_AR_NACK  8'h48
`define MRX_ST_DR_ACK   8'h50
`define MRX_ST_DR_NACK  8'h58
`define MRX_ST_IDLE     8'hF8
`define MRX_ST_MASK     8'hF8

// reset values
`define MRX_RST_BYTE    8'h00
`define MRX_RST_DATA    8'hFF

// timing: quarter of one serial bit, and the system clock period
`define MRX_QUARTER_NS  2500
`define MRX_CLK_NS      10

// bit counter: eight data bits then the acknowledge bit
`define MRX_LAST_BIT    4'h8
`define MRX_ACK_BIT     4'h0

`endif

// >>> rtl/mrx_pkg.sv
// Purpose: shared types of the two-wire master receiver block
// Assumes: nothing
// Notes:   constants live in mrx_params.svh
package mrx_pkg;

	// bus engine states
	typedef enum logic [2:0] {
		MRX_IDLE,
		MRX_START,
		MRX_BYTE,
		MRX_HOLD,
		MRX_STOP,
		MRX_LOST
	} mrx_state_e;

endpackage

// >>> rtl/mrx_sync.sv
// Purpose: two flip-flop synchroniser for levels from outside the clock domain
// Assumes: inputs are slow levels compared to the clock
// Notes:   the first stage feeds only the second stage
`timescale 1ns/100ps
module mrx_sync #(
	parameter int WIDTH = 2
) (
	input  wire logic             i_clk,
	input  wire logic             i_rst_n,
	input  wire logic [WIDTH-1:0] i_async,
	output logic      [WIDTH-1:0] o_sync
);

	logic [WIDTH-1:0] meta;   // first stage, read only by the second

	// lines idle high, so reset to ones to avoid a false edge
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			meta   <= '1;
			o_sync <= '1;
		end else begin
			meta   <= i_async;
			o_sync <= meta;
		end
	end

endmodule

// >>> rtl/mrx_tick.sv
// Purpose: quarter-bit tick for the serial line sequencer
// Assumes: i_run is high while a bus sequence is in progress
// Notes:   counter restarts whenever i_run drops, so each sequence starts aligned
`timescale 1ns/100ps
module mrx_tick #(
	parameter int QUARTER = 250
) (
	input  wire logic i_clk,
	input  wire logic i_rst_n,
	input  wire logic i_run,
	output logic      o_tick
);

	logic [15:0] count;   // cycles elapsed in the current quarter

	// count quarters, one-cycle pulse at the end of each
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			count  <= 16'h0000;
			o_tick <= 1'b0;
		end else if (!i_run) begin
			count  <= 16'h0000;
			o_tick <= 1'b0;
		end else if (count == 16'(QUARTER - 1)) begin
			count  <= 16'h0000;
			o_tick <= 1'b1;
		end else begin
			count  <= count + 16'h0001;
			o_tick <= 1'b0;
		end
	end

endmodule

// >>> testbench/mrx_monitor.sv
// Purpose: port-level checks of the two-wire master receiver
// Assumes: status is read only while the flag is set or the bus is idle
// Notes:   bound onto the top module at the foot of this file
`timescale 1ns/100ps
`include "mrx_params.svh"
module mrx_monitor (
	input wire logic        I_CLOCK,
	input wire logic        I_RST_N,
	input wire logic        I_WB_CYC,
	input wire logic        I_WB_STB,
	input wire logic        I_WB_WE,
	input wire logic [7:0]  I_WB_ADR,
	input wire logic [31:0] O_WB_DAT,
	input wire logic        O_WB_ACK,
	input wire logic        I_SCL,
	input wire logic        I_SDA,
	input wire logic        O_SCL_OE,
	input wire logic        O_SDA_OE,
	input wire logic        O_IRQ
);
	default clocking cb @(posedge I_CLOCK);
	endclocking
	default disable iff (!I_RST_N);
	// request still waiting for its answer
	sequence s_req;
		I_WB_CYC && I_WB_STB && !O_WB_ACK;
	endsequence
	// read answers from status and control
	sequence s_stat_rd;
		O_WB_ACK && !I_WB_WE && I_WB_ADR == `MRX_ADR_STAT;
	endsequence
	sequence s_ctrl_rd;
		O_WB_ACK && !I_WB_WE && I_WB_ADR == `MRX_ADR_CTRL;
	endsequence
	a_ack_follows: assert property (s_req |=> O_WB_ACK)
		else $error("bus request not answered in the next cycle");
	a_ack_single: assert property (O_WB_ACK |=> !O_WB_ACK)
		else $error("bus answer longer than one cycle");
	a_unmapped_zero: assert property (O_WB_ACK && !I_WB_WE && I_WB_ADR > `MRX_ADR_DATA |-> O_WB_DAT == 32'h0)
		else $error("unmapped read not zero");
	a_stat_prescale: assert property (s_stat_rd |-> O_WB_DAT[2:0] == 3'h0)
		else $error("status low bits not zero");
	a_flag_irq: assert property (s_ctrl_rd ##0 (O_WB_DAT[7] && O_WB_DAT[0]) |-> ##[0:1] O_IRQ)
		else $error("interrupt missing while flag and enable set");
	a_scl_stretch: assert property (s_stat_rd ##0 (O_WB_DAT[7:0] inside {8'h08, 8'h10, 8'h18, 8'h40,
		8'h48, 8'h50, 8'h58}) |-> O_SCL_OE) else $error("clock not held low during hold");
	a_lost_free: assert property (s_stat_rd ##0 O_WB_DAT[7:0] == `MRX_ST_LOST |-> !O_SCL_OE && !O_SDA_OE)
		else $error("lines not released after lost arbitration");
	a_idle_free: assert property (s_stat_rd ##0 O_WB_DAT[7:0] == `MRX_ST_IDLE |-> !O_SCL_OE && !O_SDA_OE)
		else $error("lines not released when idle");
	a_start_free: assert property ($rose(O_SDA_OE) && I_SCL |-> $past(I_SDA))
		else $error("start made on a busy bus");
endmodule
bind mrx_top mrx_monitor i_mon (
	.I_CLOCK(I_CLOCK), .I_RST_N(I_RST_N), .I_WB_CYC(I_WB_CYC), .I_WB_STB(I_WB_STB),
	.I_WB_WE(I_WB_WE), .I_WB_ADR(I_WB_ADR), .O_WB_DAT(O_WB_DAT), .O_WB_ACK(O_WB_ACK),
	.I_SCL(I_SCL), .I_SDA(I_SDA), .O_SCL_OE(O_SCL_OE), .O_SDA_OE(O_SDA_OE), .O_IRQ(O_IRQ)
);

// >>> testbench/mrx_slave_model.sv
// Purpose: behavioural slave transmitter on the two-wire bus
// Assumes: line levels resolved by the bench with pull-ups
// Notes:   i_clash acts as a rival master holding data low in address phase
`timescale 1ns/100ps
module mrx_slave_model (
	input  wire logic       i_scl,
	input  wire logic       i_sda,
	input  wire logic [6:0] i_addr,
	input  wire logic [7:0] i_data,
	input  wire logic       i_clash,
	output logic            o_sda_oe,
	output logic            o_mack
);
	logic [7:0] sh;     // bits shifted in
	logic [7:0] tx;     // byte being sent
	logic       sel;    // addressed
	logic       rd;     // read direction
	logic       adr_ph; // address byte in flight
	logic       drv;    // own pull on data
	int         cnt;    // bit index in the byte
	// rival pull only counts during an address phase
	assign o_sda_oe = drv | (i_clash & adr_ph);
	initial begin
		{sh, tx, sel, rd, adr_ph, drv, o_mack} = '0;
		cnt = 0;
	end
	// start: data falls while clock high
	always @(negedge i_sda) if (i_scl) begin
		adr_ph = 1;
		cnt = 0;
		drv = 0;
	end
	// stop: data rises while clock high, drop out
	always @(posedge i_sda) if (i_scl) begin
		adr_ph = 0;
		sel = 0;
		drv = 0;
	end
	// sample on the rising clock
	always @(posedge i_scl) begin
		if (cnt < 8)
			sh = {sh[6:0], i_sda};
		else if (sel && rd && !adr_ph)
			o_mack = !i_sda; // master answer to our byte
		cnt++;
	end
	// data only moves while the clock is low
	always @(negedge i_scl) begin
		if (cnt == 8 && adr_ph) begin
			sel = (sh[7:1] == i_addr);
			rd = sh[0];
		end
		if (cnt == 9) begin
			if (!adr_ph && rd && !o_mack)
				sel = 0; // not-acknowledge ends our sending
			adr_ph = 0;
			cnt = 0;
			tx = i_data;
		end
		drv = (cnt == 8) ? sel && (adr_ph || !rd) : sel && rd && !adr_ph && !tx[7 - cnt];
	end
endmodule

// >>> testbench/test_i2c_master_receiver.sv
// Purpose: self-checking bench of the two-wire master receiver
// Assumes: quarter bit of 4 cycles, so one bit lasts 160 ns
// Notes:   random bytes from a fixed seed, corner cases by hand
`timescale 1ns/100ps
`include "mrx_params.svh"
module test_i2c_master_receiver;
	localparam logic [7:0] GO = 8'h84; // flag clear with enable
	localparam logic [7:0] ACK = 8'h40;
	localparam logic [7:0] STA = 8'h20;
	localparam logic [7:0] STO = 8'h10;
	logic        I_CLOCK = 0, I_RST_N = 0, I_WB_CYC = 0, I_WB_STB = 0, I_WB_WE = 0;
	logic [7:0]  I_WB_ADR = '0;
	logic [31:0] I_WB_DAT = '0;
	logic [31:0] O_WB_DAT;
	logic        O_WB_ACK, O_SCL_OE, O_SDA_OE, O_IRQ, sl_oe, sl_mack, clash = 0;
	logic [6:0]  addr;
	logic [7:0]  sl_data = '0, q;
	logic [7:0]  d [5];
	int          num_errors = 0, n_compared = 0, cycles = 0, n;
	wire         scl = !O_SCL_OE;         // only the master drives the clock
	wire         sda = !(O_SDA_OE || sl_oe); // open drain with pull-up
	mrx_top #(.QUARTER(4)) i_dut (.I_CLOCK(I_CLOCK), .I_RST_N(I_RST_N), .I_WB_CYC(I_WB_CYC),
		.I_WB_STB(I_WB_STB), .I_WB_WE(I_WB_WE), .I_WB_ADR(I_WB_ADR), .I_WB_SEL(4'hF),
		.I_WB_DAT(I_WB_DAT), .O_WB_DAT(O_WB_DAT), .O_WB_ACK(O_WB_ACK), .I_SCL(scl), .O_SCL(),
		.O_SCL_OE(O_SCL_OE), .I_SDA(sda), .O_SDA(), .O_SDA_OE(O_SDA_OE), .O_IRQ(O_IRQ));
	mrx_slave_model i_slave (.i_scl(scl), .i_sda(sda), .i_addr(addr), .i_data(sl_data),
		.i_clash(clash), .o_sda_oe(sl_oe), .o_mack(sl_mack));
	always #5 I_CLOCK = !I_CLOCK;
	// hang guard: counts as a mismatch
	always @(posedge I_CLOCK) begin
		cycles++;
		if (cycles == 20000) begin
			num_errors++;
			wrap_up();
		end
	end
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		n_compared++;
		if (seen !== exp) begin
			num_errors++;
			$display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	// one classic cycle, held until ack is sampled; read byte lands in q
	task automatic wb(input logic we, input logic [7:0] adr, input logic [7:0] wd);
		int k;
		k = 0;
		I_WB_CYC <= 1;
		I_WB_STB <= 1;
		I_WB_WE <= we;
		I_WB_ADR <= adr;
		I_WB_DAT <= {24'h0, wd};
		do begin
			@(posedge I_CLOCK);
			k++;
		end while (O_WB_ACK !== 1'b1 && k < 20);
		if (k == 20) num_errors++;
		q = O_WB_DAT[7:0];
		I_WB_CYC <= 0;
		I_WB_STB <= 0;
		@(posedge I_CLOCK);
	endtask
	// poll control until bit b reads v
	task automatic wait_bit(input int b, input logic v);
		int k;
		k = 0;
		do begin
			wb(0, `MRX_ADR_CTRL, 8'h00);
			k++;
		end while (q[b] !== v && k < 400);
		if (k == 400) num_errors++;
	endtask
	// clear the flag with a request, irq enable random, then check the code
	task automatic step(input logic [7:0] c, input logic [7:0] code);
		logic ie;
		ie = 1'($urandom);
		wb(1, `MRX_ADR_CTRL, c | 8'(ie));
		wait_bit(`MRX_B_FLAG, 1);
		chk(8'(O_IRQ), 8'(ie));
		wb(0, `MRX_ADR_STAT, 8'h00);
		chk(q, code);
	endtask
	task automatic wrap_up();
		$display("compared %0d, mismatches %0d", n_compared, num_errors);
		if (num_errors == 0 && n_compared > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	initial begin
		addr = 7'h40 | 7'($urandom(32'h948A62F7)); // top bit set so the rival wins
		for (int i = 0; i < 5; i++) d[i] = 8'($urandom);
		d[1] = 8'hFF; // all ones: slave never pulls
		n = 2 + $urandom % 3;
		repeat (10) @(posedge I_CLOCK);
		I_RST_N <= 1;
		@(posedge I_CLOCK);
		// reset values, unmapped word, dropped data write
		wb(0, `MRX_ADR_CTRL, 8'h00);
		chk(q, `MRX_RST_BYTE);
		wb(0, `MRX_ADR_STAT, 8'h00);
		chk(q, `MRX_ST_IDLE);
		wb(0, 8'h0C, 8'h00);
		chk(q, 8'h00);
		wb(1, `MRX_ADR_DATA, 8'h5A);
		wb(0, `MRX_ADR_DATA, 8'h00);
		chk(q, `MRX_RST_DATA);
		wb(0, `MRX_ADR_CTRL, 8'h00);
		chk(q, 8'h08);
		// start, read address, random bytes with the last refused
		step(GO | STA, `MRX_ST_START);
		sl_data = d[0];
		wb(1, `MRX_ADR_DATA, {addr, 1'b1});
		wb(0, `MRX_ADR_CTRL, 8'h00);
		chk(q & 8'h08, 8'h00);
		step(GO | ACK, `MRX_ST_AR_ACK);
		for (int i = 0; i < n; i++) begin
			sl_data = d[i + 1];
			step(GO | (i < n - 1 ? ACK : 8'h00), i < n - 1 ? `MRX_ST_DR_ACK : `MRX_ST_DR_NACK);
			chk(8'(sl_mack), 8'(i < n - 1));
			wb(0, `MRX_ADR_DATA, 8'h00);
			chk(q, d[i]);
		end
		// repeated start into write, then to an absent slave
		step(GO | STA, `MRX_ST_RESTART);
		wb(1, `MRX_ADR_DATA, {addr, 1'b0});
		step(GO, `MRX_ST_AW_ACK);
		step(GO | STA, `MRX_ST_RESTART);
		wb(1, `MRX_ADR_DATA, {~addr, 1'b1});
		step(GO, `MRX_ST_AR_NACK);
		step(GO | STA | STO, `MRX_ST_START);
		wb(0, `MRX_ADR_CTRL, 8'h00);
		chk(q & 8'h10, 8'h00);
		// rival master wins the address, retry waits for its stop
		clash = 1;
		wb(1, `MRX_ADR_DATA, {addr, 1'b1});
		step(GO, `MRX_ST_LOST);
		wb(1, `MRX_ADR_CTRL, GO | STA);
		repeat (300) @(posedge I_CLOCK);
		wb(0, `MRX_ADR_CTRL, 8'h00);
		chk(q & 8'h80, 8'h00);
		clash = 0;
		wait_bit(`MRX_B_FLAG, 1);
		wb(0, `MRX_ADR_STAT, 8'h00);
		chk(q, `MRX_ST_START);
		// a go in 0x08 sends the address, so address an absent slave first
		wb(1, `MRX_ADR_DATA, {~addr, 1'b1});
		step(GO, `MRX_ST_AR_NACK);
		// plain stop; the request bit clears by itself
		wb(1, `MRX_ADR_CTRL, GO | STO);
		wait_bit(`MRX_B_STOP, 0);
		wb(0, `MRX_ADR_STAT, 8'h00);
		chk(q, `MRX_ST_IDLE);
		wrap_up();
	end
endmodule
